//--- hw/pcm_top.sv
// Pad control and multiplexing: global pad register and a bank of
// per-pad configuration registers with sleep override steering.
// Assumes a plain register port on clk; deep_sleep is asynchronous.
// Overview of operation
// - Global bits 7:0 and 29:27 each weakly pull down one supply domain.
// - Global bits 18:8 and 26:21 pick 4.7K pull-up on one, 72K on zero.
// - Bits 31,30,20,19 set card clock polarity 3..0 when not in card mode.
// - Bit 17 sets the pull-up strength of card data pads 2 and 3 together.
// - Bit 6 pulls down the general I/O domain and its four sub-domains.
// - The global register is at offset zero, read/write, reset to zero.
// - Per-pad bits 31:10 are reserved and read as zero.
// - Per-pad bits 5:4 select function mode 0 to 3.
// - Per-pad bits 7 and 6 set function mode pull-up and pull-down.
// - Per-pad bits 3 and 2 set deep sleep pull-up and pull-down.
// - Per-pad bits 1 and 0 set deep sleep input and output enables.
// - Each per-pad register resets to its own pin specific value.
module pcm_top
    import pcm_pkg::*;
#(
    parameter logic [NUM_PADS*PAD_CFG_W-1:0] PAD_RESET_VALUES =
        {NUM_PADS{PAD_RESET_DEFAULT}}
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic deep_sleep,
    input wire logic [NUM_PADS-1:0] pad_func_oe,
    output logic [NUM_DOMAINS-1:0] domain_pulldown,
    output logic [NUM_IO_SUBDOMAINS-1:0] general_io_domain_pulldown,
    output logic [NUM_PUS-1:0] pullup_strength,
    output logic card2_data_pullup_strength,
    output logic card3_data_pullup_strength,
    output logic [3:0] card_clock_polarity,
    output logic [NUM_PADS*2-1:0] pad_func_sel,
    output logic [NUM_PADS*2-1:0] pad_drive,
    output logic [NUM_PADS-1:0] pad_pullup_en,
    output logic [NUM_PADS-1:0] pad_pulldown_en,
    output logic [NUM_PADS-1:0] pad_input_en,
    output logic [NUM_PADS-1:0] pad_output_en,
    output logic sleep_active
);
    logic [31:0] global_ff;
    logic sleep_sync;
    logic [NUM_PADS*PAD_CFG_W-1:0] pad_cfg;
    logic [NUM_PADS*2-1:0] nxt_sel;
    logic [NUM_PADS*2-1:0] nxt_drv;
    logic [NUM_PADS-1:0] nxt_pu;
    logic [NUM_PADS-1:0] nxt_pd;
    logic [NUM_PADS-1:0] nxt_sie;
    logic [NUM_PADS-1:0] nxt_soe;
    logic [NUM_PADS-1:0] nxt_force;
    logic [NUM_PADS-1:0] pad_wr;
    logic [31:0] nxt_rdata;
    logic [3:0] nxt_polarity;

    // Per-pad registers follow the global one, one word each
    function automatic logic [11:0] pad_offset(input int idx);
        pad_offset = PAD_BASE_OFFSET + 12'(idx * 4);
    endfunction

    // Shared by the write decode and the read mux
    function automatic logic is_global(input logic [11:0] a);
        is_global = (a == GLOBAL_OFFSET);
    endfunction

    pcm_sync u_sleep_sync
    (
        .clk(clk),
        .reset(reset),
        .async_in(deep_sleep),
        .sync_out(sleep_sync)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_PADS; g++)
        begin : g_pad
            assign pad_wr[g] = wr_en && (addr == pad_offset(g));
            pcm_pad_cfg #(
                .RESET_VALUE(PAD_RESET_VALUES[g*PAD_CFG_W +: PAD_CFG_W])
            ) u_pad
            (
                .clk(clk),
                .reset(reset),
                .wr_sel(pad_wr[g]),
                .wr_data(wdata[PAD_CFG_W-1:0]),
                .sleep(sleep_sync),
                .cfg(pad_cfg[g*PAD_CFG_W +: PAD_CFG_W]),
                .nxt_func_sel(nxt_sel[g*2 +: 2]),
                .nxt_drive(nxt_drv[g*2 +: 2]),
                .nxt_pu(nxt_pu[g]),
                .nxt_pd(nxt_pd[g]),
                .nxt_sleep_ie(nxt_sie[g]),
                .nxt_sleep_oe(nxt_soe[g]),
                .nxt_sleep_force(nxt_force[g])
            );
        end
    endgenerate

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            global_ff <= GLOBAL_RESET;
        end
        else if (wr_en && is_global(addr))
        begin
            global_ff <= wdata;
        end
    end

    // Unmapped addresses read as zero
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (is_global(addr))
        begin
            nxt_rdata = global_ff;
        end
        else
        begin
            for (int i = 0; i < NUM_PADS; i++)
            begin
                if (addr == pad_offset(i))
                begin
                    // Upper bits stay zero as reserved
                    nxt_rdata = {22'h0,
                        pad_cfg[i*PAD_CFG_W +: PAD_CFG_W]};
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rdata <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            rdata <= nxt_rdata;
        end
        else
        begin
            rdata <= 32'h0000_0000;
        end
    end

    // Polarity only reaches a card clock pad not in card mode
    always_comb
    begin
        nxt_polarity[3] = global_ff[POL3_BIT];
        nxt_polarity[2] = global_ff[POL2_BIT];
        nxt_polarity[1] = global_ff[POL1_BIT];
        nxt_polarity[0] = global_ff[POL0_BIT];
        for (int k = 0; k < 4; k++)
        begin
            if (k < NUM_PADS && nxt_sel[k*2 +: 2] == CARD_FUNC_MODE)
            begin
                nxt_polarity[k] = 1'b0;
            end
        end
    end

    // Global fan-out is registered so every output leaves a flop
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            domain_pulldown <= '0;
            general_io_domain_pulldown <= '0;
            pullup_strength <= '0;
            card2_data_pullup_strength <= 1'b0;
            card3_data_pullup_strength <= 1'b0;
            card_clock_polarity <= 4'h0;
        end
        else
        begin
            domain_pulldown <= {global_ff[DOM_HI_HI:DOM_HI_LO],
                global_ff[DOM_LO_HI:DOM_LO_LO]};
            general_io_domain_pulldown <=
                {NUM_IO_SUBDOMAINS{global_ff[GENERAL_IO_PD_BIT]}};
            pullup_strength <= {global_ff[PUS_HI_HI:PUS_HI_LO],
                global_ff[PUS_LO_HI:PUS_LO_LO]};
            card2_data_pullup_strength <=
                global_ff[CARD23_DATA_PUS_BIT];
            card3_data_pullup_strength <=
                global_ff[CARD23_DATA_PUS_BIT];
            card_clock_polarity <= nxt_polarity;
        end
    end

    // In sleep the enables come from the register, else input enable is on and output enable comes from the function
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pad_func_sel <= '0;
            pad_drive <= '0;
            pad_pullup_en <= '0;
            pad_pulldown_en <= '0;
            pad_input_en <= '0;
            pad_output_en <= '0;
            sleep_active <= 1'b0;
        end
        else
        begin
            pad_func_sel <= nxt_sel;
            pad_drive <= nxt_drv;
            pad_pullup_en <= nxt_pu;
            pad_pulldown_en <= nxt_pd;
            for (int p = 0; p < NUM_PADS; p++)
            begin
                if (nxt_force[p])
                begin
                    pad_input_en[p] <= nxt_sie[p];
                    pad_output_en[p] <= nxt_soe[p];
                end
                else
                begin
                    pad_input_en[p] <= 1'b1;
                    pad_output_en[p] <= pad_func_oe[p];
                end
            end
            sleep_active <= sleep_sync;
        end
    end

    // Register port checks: read data stands one cycle after the strobe
    a_global_reads_back: assert property (
        @(posedge clk) disable iff (reset)
        rd_en && addr == GLOBAL_OFFSET |=> rdata == $past(global_ff))
        else $error("global register read mismatch");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (reset)
        rd_en && addr != GLOBAL_OFFSET |=> rdata[31:10] == 22'h0)
        else $error("reserved per-pad bits not zero");

    a_rdata_idle: assert property (
        @(posedge clk) disable iff (reset)
        !rd_en |=> rdata == 32'h0000_0000)
        else $error("read data not cleared without a read");

    // Global fan-out lands two edges after the write strobe
    a_domain_pd_follow: assert property (
        @(posedge clk) disable iff (reset)
        wr_en && addr == GLOBAL_OFFSET ##1 1'b1
        |=> domain_pulldown[0] == $past(wdata[0], 2))
        else $error("domain pull-down not following write");

    a_domain_pd_high: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> domain_pulldown[10:8] == $past(global_ff[29:27]))
        else $error("upper domain pull-downs wrong");

    a_io_sub_all: assert property (
        @(posedge clk) disable iff (reset)
        general_io_domain_pulldown == {4{domain_pulldown[6]}})
        else $error("general io sub-domain pull-downs differ");

    a_card_data_pair: assert property (
        @(posedge clk) disable iff (reset)
        card2_data_pullup_strength == card3_data_pullup_strength)
        else $error("card data pull-up strengths differ");

    a_pus_lowbit: assert property (
        @(posedge clk) disable iff (reset)
        ##1 pullup_strength[0] == $past(global_ff[8]))
        else $error("pull-up strength bit wrong");

    a_pus_high: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> pullup_strength[16:11] == $past(global_ff[26:21]))
        else $error("upper pull-up strengths wrong");

    // Polarity is gated by the select that the pad shows in the same cycle
    a_pol_gate_one: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> card_clock_polarity[1] ==
            (pad_func_sel[3:2] != CARD_FUNC_MODE && $past(global_ff[POL1_BIT])))
        else $error("card clock one polarity wrong");

    a_pol_gate_three: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> card_clock_polarity[3] ==
            (pad_func_sel[7:6] != CARD_FUNC_MODE && $past(global_ff[POL3_BIT])))
        else $error("card clock three polarity wrong");

    // Pad steering checks on pad 0, the others share the same module
    a_sleep_oe_pad0: assert property (
        @(posedge clk) disable iff (reset)
        nxt_force[0] |=> pad_output_en[0] == $past(pad_cfg[0]))
        else $error("sleep output enable not applied");

    a_sleep_ie_pad0: assert property (
        @(posedge clk) disable iff (reset)
        nxt_force[0] |=> pad_input_en[0] == $past(pad_cfg[1]))
        else $error("sleep input enable not applied");

    a_func_en_pad0: assert property (
        @(posedge clk) disable iff (reset)
        !nxt_force[0] |=> pad_input_en[0] &&
            pad_output_en[0] == $past(pad_func_oe[0]))
        else $error("function enables not applied");

    a_func_pu_pad0: assert property (
        @(posedge clk) disable iff (reset)
        !sleep_sync |=> pad_pullup_en[0] == $past(pad_cfg[7]))
        else $error("function pull-up not applied");

    a_sleep_pd_pad0: assert property (
        @(posedge clk) disable iff (reset)
        sleep_sync |=> pad_pulldown_en[0] == $past(pad_cfg[2]))
        else $error("sleep pull-down not applied");

    a_sel_pad0: assert property (
        @(posedge clk) disable iff (reset)
        ##1 pad_func_sel[1:0] == $past(pad_cfg[5:4]))
        else $error("function select not applied");

    a_drive_pad0: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> pad_drive[1:0] == $past(pad_cfg[9:8]))
        else $error("drive strength not passed through");

    a_sleep_flag: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> sleep_active == $past(sleep_sync))
        else $error("sleep flag not following synchroniser");
endmodule

//--- hw/pcm_pkg.sv
// Constants for the pad control and multiplexing block.
// Assumes a single clock domain and a plain register port.
package pcm_pkg;
    localparam int NUM_PADS = 8;
    localparam logic [11:0] GLOBAL_OFFSET = 12'h000;
    localparam logic [11:0] PAD_BASE_OFFSET = 12'h004;
    localparam logic [31:0] GLOBAL_RESET = 32'h0000_0000;
    localparam logic [9:0] PAD_RESET_DEFAULT = 10'h100;
    localparam int PAD_CFG_W = 10;
    // Global register fields
    localparam int DOM_LO_HI = 7;
    localparam int DOM_LO_LO = 0;
    localparam int DOM_HI_HI = 29;
    localparam int DOM_HI_LO = 27;
    localparam int PUS_LO_HI = 18;
    localparam int PUS_LO_LO = 8;
    localparam int PUS_HI_HI = 26;
    localparam int PUS_HI_LO = 21;
    localparam int POL3_BIT = 31;
    localparam int POL2_BIT = 30;
    localparam int POL1_BIT = 20;
    localparam int POL0_BIT = 19;
    localparam int CARD23_DATA_PUS_BIT = 17;
    localparam int GENERAL_IO_PD_BIT = 6;
    localparam int NUM_DOMAINS = 11;
    localparam int NUM_PUS = 17;
    localparam int NUM_IO_SUBDOMAINS = 4;
    // Per-pad fields
    localparam int DRV_HI = 9;
    localparam int DRV_LO = 8;
    localparam int FUNC_PU_BIT = 7;
    localparam int FUNC_PD_BIT = 6;
    localparam int SEL_HI = 5;
    localparam int SEL_LO = 4;
    localparam int SLP_PU_BIT = 3;
    localparam int SLP_PD_BIT = 2;
    localparam int SLP_IE_BIT = 1;
    localparam int SLP_OE_BIT = 0;
    localparam logic [1:0] MODE0 = 2'h0;
    localparam logic [1:0] MODE1 = 2'h1;
    localparam logic [1:0] MODE2 = 2'h2;
    localparam logic [1:0] MODE3 = 2'h3;
    // Which function mode is the card function on the card clock pads
    localparam logic [1:0] CARD_FUNC_MODE = 2'h0;
    localparam int SYNC_STAGES = 3;
endpackage

//--- hw/pcm_sync.sv
// Three-stage synchroniser with agreement filter for one level.
// Assumes the input is asynchronous to clk.
module pcm_sync
    import pcm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic [SYNC_STAGES-1:0] stage_ff;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stage_ff <= '0;
        end
        else
        begin
            stage_ff <= {stage_ff[SYNC_STAGES-2:0], async_in};
        end
    end

    // Only the second and third stages are examined
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync_out <= 1'b0;
        end
        else if (stage_ff[1] == stage_ff[2])
        begin
            sync_out <= stage_ff[2];
        end
    end
endmodule

//--- hw/pcm_pad_cfg.sv
// One per-pad configuration register with its pad steering.
// Assumes the parent decodes the address into a write select.
module pcm_pad_cfg
    import pcm_pkg::*;
#(
    parameter logic [PAD_CFG_W-1:0] RESET_VALUE = PAD_RESET_DEFAULT
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_sel,
    input wire logic [PAD_CFG_W-1:0] wr_data,
    input wire logic sleep,
    output logic [PAD_CFG_W-1:0] cfg,
    output logic [1:0] nxt_func_sel,
    output logic [1:0] nxt_drive,
    output logic nxt_pu,
    output logic nxt_pd,
    output logic nxt_sleep_ie,
    output logic nxt_sleep_oe,
    output logic nxt_sleep_force
);
    logic [PAD_CFG_W-1:0] cfg_ff;

    assign cfg = cfg_ff;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cfg_ff <= RESET_VALUE;
        end
        else if (wr_sel)
        begin
            cfg_ff <= wr_data;
        end
    end

    always_comb
    begin
        nxt_func_sel = cfg_ff[SEL_HI:SEL_LO];
        nxt_drive = cfg_ff[DRV_HI:DRV_LO];
        nxt_sleep_force = sleep;
        nxt_sleep_ie = cfg_ff[SLP_IE_BIT];
        nxt_sleep_oe = cfg_ff[SLP_OE_BIT];
        if (sleep)
        begin
            nxt_pu = cfg_ff[SLP_PU_BIT];
            nxt_pd = cfg_ff[SLP_PD_BIT];
        end
        else
        begin
            nxt_pu = cfg_ff[FUNC_PU_BIT];
            nxt_pd = cfg_ff[FUNC_PD_BIT];
        end
    end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the pad control and multiplexing block.
// Assumes the plain register port with one-cycle read data.
module testbench
    import pcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Distinct per-pad defaults so a shared reset value cannot pass
    localparam logic [NUM_PADS*PAD_CFG_W-1:0] RST_VALS = {10'h18a,
        10'h106, 10'h146, 10'h101, 10'h10a, 10'h180, 10'h102, 10'h100};

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic deep_sleep = 1'b0;
    logic [NUM_PADS-1:0] pad_func_oe = 8'h96;
    logic [31:0] rdata;
    logic [NUM_DOMAINS-1:0] domain_pulldown;
    logic [NUM_IO_SUBDOMAINS-1:0] general_io_domain_pulldown;
    logic [NUM_PUS-1:0] pullup_strength;
    logic card2_data_pullup_strength;
    logic card3_data_pullup_strength;
    logic [3:0] card_clock_polarity;
    logic [NUM_PADS*2-1:0] pad_func_sel;
    logic [NUM_PADS*2-1:0] pad_drive;
    logic [NUM_PADS-1:0] pad_pullup_en;
    logic [NUM_PADS-1:0] pad_pulldown_en;
    logic [NUM_PADS-1:0] pad_input_en;
    logic [NUM_PADS-1:0] pad_output_en;
    logic sleep_active;
    logic [PAD_CFG_W-1:0] cfg [NUM_PADS];
    logic [3:0] pol_en = 4'h0;
    logic [31:0] d;
    int num_errors = 0;
    int cmp_count = 0;

    pcm_top #(.PAD_RESET_VALUES(RST_VALS)) uut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .deep_sleep(deep_sleep), .pad_func_oe(pad_func_oe),
        .domain_pulldown(domain_pulldown),
        .general_io_domain_pulldown(general_io_domain_pulldown),
        .pullup_strength(pullup_strength),
        .card2_data_pullup_strength(card2_data_pullup_strength),
        .card3_data_pullup_strength(card3_data_pullup_strength),
        .card_clock_polarity(card_clock_polarity),
        .pad_func_sel(pad_func_sel), .pad_drive(pad_drive),
        .pad_pullup_en(pad_pullup_en), .pad_pulldown_en(pad_pulldown_en),
        .pad_input_en(pad_input_en), .pad_output_en(pad_output_en),
        .sleep_active(sleep_active)
    );

    always #2 clk = ~clk;

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time,
                     what, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Data is sampled in the one cycle where it stands
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    function automatic logic [11:0] pad_addr(input int k);
        return PAD_BASE_OFFSET + 12'(4 * k);
    endfunction

    task automatic chk_reset;
        logic [31:0] v;
        rd(GLOBAL_OFFSET, v);
        chk(v, GLOBAL_RESET, "global reset");
        for (int k = 0; k < NUM_PADS; k++)
        begin
            rd(pad_addr(k), v);
            chk(v, {22'h0, RST_VALS[k*PAD_CFG_W +: PAD_CFG_W]},
                "pad rst");
        end
    endtask

    task automatic gchk(input logic [31:0] g);
        logic [31:0] v;
        wr(GLOBAL_OFFSET, g);
        settle();
        chk(32'(domain_pulldown), 32'({g[29:27], g[7:0]}),
            "dom pd");
        chk(32'(general_io_domain_pulldown), 32'({4{g[6]}}),
            "io pd");
        chk(32'(pullup_strength), 32'({g[26:21], g[18:8]}),
            "pus");
        chk(32'({card3_data_pullup_strength, card2_data_pullup_strength}),
            32'({2{g[17]}}), "card data pus");
        chk(32'(card_clock_polarity),
            32'({g[31], g[30], g[20], g[19]} & pol_en), "clk pol");
        rd(GLOBAL_OFFSET, v);
        chk(v, g, "global readback");
    endtask

    task automatic chk_pads(input logic slp);
        logic [NUM_PADS-1:0] pu, pd, ie, oe;
        logic [NUM_PADS*2-1:0] sel, drv;
        for (int k = 0; k < NUM_PADS; k++)
        begin
            pu[k] = slp ? cfg[k][3] : cfg[k][7];
            pd[k] = slp ? cfg[k][2] : cfg[k][6];
            ie[k] = slp ? cfg[k][1] : 1'b1;
            oe[k] = slp ? cfg[k][0] : pad_func_oe[k];
            sel[2*k +: 2] = cfg[k][5:4];
            drv[2*k +: 2] = cfg[k][9:8];
        end
        chk(32'(sleep_active), 32'(slp), "sleep flag");
        chk(32'(pad_func_sel), 32'(sel), "func sel");
        chk(32'(pad_drive), 32'(drv), "drive");
        chk(32'(pad_pullup_en), 32'(pu), "pullup");
        chk(32'(pad_pulldown_en), 32'(pd), "pulldown");
        chk(32'(pad_input_en), 32'(ie), "input en");
        chk(32'(pad_output_en), 32'(oe), "output en");
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        chk_reset();
        // All pads still in the card mode, so polarity stays gated
        // Domain pull-downs are set while every regulator is still on
        gchk(32'ha5c3_5a3c);
        for (int k = 0; k < NUM_PADS; k++)
        begin
            cfg[k] = 10'((k + 1) * 10'h0d7);
            cfg[k][5:4] = 2'(k);
            if (k < 4)
                pol_en[k] = (2'(k) != CARD_FUNC_MODE);
            wr(pad_addr(k), {22'h3fffff, cfg[k]});
        end
        settle();
        for (int k = 0; k < NUM_PADS; k++)
        begin
            rd(pad_addr(k), d);
            chk(d, {22'h0, cfg[k]}, "pad readback");
        end
        chk_pads(1'b0);
        gchk(32'h5a3c_a5c3);
        gchk(32'ha5c3_5a3c);
        // Function enables must be ignored while asleep
        @(posedge clk);
        deep_sleep <= 1'b1;
        pad_func_oe <= 8'h69;
        repeat (8) @(posedge clk);
        #1;
        chk_pads(1'b1);
        @(posedge clk);
        deep_sleep <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk_pads(1'b0);
        // Unmapped place: write dropped, read gives zero
        wr(pad_addr(NUM_PADS), 32'hffff_ffff);
        rd(pad_addr(NUM_PADS), d);
        chk(d, 32'h0000_0000, "unmapped read");
        @(posedge clk);
        #1;
        chk(rdata, 32'h0000_0000, "rdata after read");
        rd(GLOBAL_OFFSET, d);
        chk(d, 32'ha5c3_5a3c, "global kept");
        // Second reset in mid-run restores every default
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        chk_reset();
        finish_test();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
